/* core/rps_defs.svh */
/*
  Constants of the rotor position sampler: register byte addresses, field
  positions, reset values and sizes.
  Assumes it is included by its bare name from the package and design files.
*/
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH

// ---------------------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------------------
`define RPS_ADDR_CONTROL     8'h00
`define RPS_ADDR_CONFIG      8'h04
`define RPS_ADDR_PATTERN     8'h08
`define RPS_ADDR_STATUS      8'h0C
`define RPS_ADDR_IRQ_STATUS  8'h10
`define RPS_ADDR_IRQ_ENABLE  8'h14
`define RPS_ADDR_IRQ_CLEAR   8'h18
`define RPS_ADDR_PIN_DIR     8'h1C

// ---------------------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------------------
`define RPS_CTL_SOFT_STOP    7
`define RPS_CTL_SOFT_START   6
`define RPS_CTL_TSTOP_EN     5
`define RPS_CTL_TSTART_EN    4
`define RPS_CTL_SINGLE_PIN   3
`define RPS_CTL_RECOUNT      2
`define RPS_CTL_DETECT_MODE  1

// ---------------------------------------------------------------------------
// config register fields
// ---------------------------------------------------------------------------
`define RPS_CFG_PERIOD_HI    7
`define RPS_CFG_PERIOD_LO    6
`define RPS_CFG_MODE_HI      5
`define RPS_CFG_MODE_LO      4
`define RPS_CFG_COUNT_HI     3
`define RPS_CFG_COUNT_LO     0

// ---------------------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------------------
`define RPS_STS_ACTIVE       3
`define RPS_STS_REF_HI       2
`define RPS_STS_REF_LO       0

// ---------------------------------------------------------------------------
// reset values and sizes
// ---------------------------------------------------------------------------
`define RPS_CONFIG_RESET     8'h00
`define RPS_CONTROL_RESET    8'h00
`define RPS_PRESCALE_BITS    5
`define RPS_AXI_RESP_OKAY    2'h0
`define RPS_AXI_RESP_SLVERR  2'h2

`endif

/* core/rps_pkg.sv */
/*
  Types of the rotor position sampler.
  Assumes rps_defs.svh is on the include path.
*/
`include "rps_defs.svh"

package rps_pkg;

  typedef enum logic [1:0] {
    RPS_SAMPLE_PWM_ON,
    RPS_SAMPLE_ALWAYS,
    RPS_SAMPLE_LOW_SIDE,
    RPS_SAMPLE_RESERVED
  } rps_mode_t;

  typedef enum logic [1:0] {
    RPS_IDLE,
    RPS_RUN,
    RPS_STOPPING
  } rps_state_t;

endpackage : rps_pkg

/* core/rps_sync.sv */
/*
  Two flip-flop synchroniser for a vector of pin levels.
  Assumes pins are asynchronous to aclk; the first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none

module rps_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : rps_sync

`default_nettype wire

/* core/rps_prescaler.sv */
/*
  Free running prescaler giving one-cycle ticks at aclk/4, /8, /16 or /32.
  Assumes select comes from a register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rps_defs.svh"

module rps_prescaler (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] period_select,
  output logic            tick
);

  logic [`RPS_PRESCALE_BITS-1:0] count;
  logic [`RPS_PRESCALE_BITS-1:0] mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else begin
      count <= count + 5'h01;
    end
  end

  // period is 2^(select+2) cycles
  always_comb begin
    case (period_select)
      2'h0:    mask = 5'h03;
      2'h1:    mask = 5'h07;
      2'h2:    mask = 5'h0F;
      default: mask = 5'h1F;
    endcase
  end

  assign tick = ((count & mask) == mask);

endmodule : rps_prescaler

`default_nettype wire

/* core/rps_sampler.sv */
/*
  Rotor position sampler with AXI4-Lite registers: counts consecutive pin
  matches (or departures) per sample tick and raises detection and irq.
  Assumes phase, PWM, low-side and timer trigger inputs are asynchronous.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rps_defs.svh"

module rps_sampler (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        phase_u_position_in,
  input  wire logic        phase_v_position_in,
  input  wire logic        phase_w_position_in,
  input  wire logic        pwm_on_in,
  input  wire logic        low_side_on_in,
  input  wire logic        timer_start_trigger,
  input  wire logic        timer_stop_trigger,
  output logic             position_detect,
  output logic             irq
);

  // -------------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------------
  logic [6:0] pins_sync;
  rps_sync #(.WIDTH(7)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({timer_stop_trigger, timer_start_trigger, low_side_on_in, pwm_on_in,
                phase_w_position_in, phase_v_position_in, phase_u_position_in}),
    .sync_out (pins_sync)
  );
  logic [2:0] phase_level;
  logic       pwm_on;
  logic       low_side_on;
  logic       tstart_lvl;
  logic       tstop_lvl;
  logic       tstart_prev;
  logic       tstop_prev;
  logic       pwm_prev;
  assign phase_level = pins_sync[2:0];
  assign pwm_on      = pins_sync[3];
  assign low_side_on = pins_sync[4];
  assign tstart_lvl  = pins_sync[5];
  assign tstop_lvl   = pins_sync[6];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tstart_prev <= 1'b0;
      tstop_prev  <= 1'b0;
      pwm_prev    <= 1'b0;
    end else begin
      tstart_prev <= tstart_lvl;
      tstop_prev  <= tstop_lvl;
      pwm_prev    <= pwm_on;
    end
  end

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  logic [7:0] config_reg;
  logic [7:0] control_reg;
  logic [2:0] motor_output_pattern;
  logic [2:0] pin_is_output;
  logic       irq_status;
  logic       irq_enable;
  logic        wr_fire;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic        soft_start_pulse;
  logic        soft_stop_pulse;
  logic        irq_clear_pulse;
  rps_pkg::rps_mode_t sample_mode_select;
  logic [1:0]         sample_period_select;
  logic [3:0]         match_count_target;
  assign sample_period_select = config_reg[`RPS_CFG_PERIOD_HI:`RPS_CFG_PERIOD_LO];
  assign sample_mode_select   = rps_pkg::rps_mode_t'(config_reg[`RPS_CFG_MODE_HI:`RPS_CFG_MODE_LO]);
  assign match_count_target   = config_reg[`RPS_CFG_COUNT_HI:`RPS_CFG_COUNT_LO];
  logic timer_stop_enable;
  logic timer_start_enable;
  logic single_pin_select;
  logic recount_per_pwm;
  logic detect_mode_select;
  assign timer_stop_enable  = control_reg[`RPS_CTL_TSTOP_EN];
  assign timer_start_enable = control_reg[`RPS_CTL_TSTART_EN];
  assign single_pin_select  = control_reg[`RPS_CTL_SINGLE_PIN];
  assign recount_per_pwm    = control_reg[`RPS_CTL_RECOUNT];
  assign detect_mode_select = control_reg[`RPS_CTL_DETECT_MODE];

  // -------------------------------------------------------------------------
  // axi4-lite write channel
  // -------------------------------------------------------------------------
  logic aw_held;
  logic w_held;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= 8'h00;
      wr_data      <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RPS_AXI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr[7:5] == 3'h0 && wr_addr[1:0] == 2'h0 && wr_addr != `RPS_ADDR_STATUS
                         && wr_addr != `RPS_ADDR_IRQ_STATUS) ? `RPS_AXI_RESP_OKAY : `RPS_AXI_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // start and stop bits act on the write and are never stored
  assign soft_start_pulse = wr_fire && wr_addr == `RPS_ADDR_CONTROL && wr_data[`RPS_CTL_SOFT_START];
  assign soft_stop_pulse  = wr_fire && wr_addr == `RPS_ADDR_CONTROL && wr_data[`RPS_CTL_SOFT_STOP];
  assign irq_clear_pulse  = wr_fire && wr_addr == `RPS_ADDR_IRQ_CLEAR && wr_data[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg           <= `RPS_CONFIG_RESET;
      control_reg          <= `RPS_CONTROL_RESET;
      motor_output_pattern <= 3'h0;
      pin_is_output        <= 3'h0;
      irq_enable           <= 1'b0;
    end else if (wr_fire) begin
      case (wr_addr)
        `RPS_ADDR_CONFIG:     config_reg           <= wr_data[7:0];
        `RPS_ADDR_CONTROL:    control_reg          <= {2'h0, wr_data[5:1], 1'b0};
        `RPS_ADDR_PATTERN:    motor_output_pattern <= wr_data[2:0];
        `RPS_ADDR_PIN_DIR:    pin_is_output        <= wr_data[2:0];
        `RPS_ADDR_IRQ_ENABLE: irq_enable           <= wr_data[0];
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // sampling control
  // -------------------------------------------------------------------------
  rps_pkg::rps_state_t state;
  logic       tick;
  logic       window_open;
  logic [2:0] seen;
  logic [2:0] reference;
  logic [2:0] expect_mask;
  logic       hit;
  logic [3:0] run_count;
  logic [3:0] need;
  logic       detect_now;
  logic       start_req;
  logic       stop_req;
  rps_prescaler u_prescaler (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .period_select (sample_period_select),
    .tick          (tick)
  );
  assign seen        = phase_level & ~pin_is_output;
  assign expect_mask = single_pin_select ? 3'h1 : 3'h7;
  assign need        = (match_count_target == 4'h0) ? 4'h1 : match_count_target;
  assign start_req   = soft_start_pulse || (timer_start_enable && tstart_lvl && !tstart_prev);
  assign stop_req    = soft_stop_pulse || (timer_stop_enable && tstop_lvl && !tstop_prev);

  always_comb begin
    case (sample_mode_select)
      rps_pkg::RPS_SAMPLE_PWM_ON:   window_open = pwm_on;
      rps_pkg::RPS_SAMPLE_ALWAYS:   window_open = 1'b1;
      rps_pkg::RPS_SAMPLE_LOW_SIDE: window_open = low_side_on;
      default:                      window_open = 1'b0;
    endcase
  end

  // ordinary mode wants a match with the pattern, change mode a departure from the reference caught at start
  always_comb begin
    if (detect_mode_select) begin
      hit = ((seen ^ reference) & expect_mask) != 3'h0;
    end else begin
      hit = ((seen ^ motor_output_pattern) & expect_mask) == 3'h0;
    end
  end

  logic sampling;
  logic do_sample;
  assign sampling   = state != rps_pkg::RPS_IDLE;
  assign do_sample  = sampling && tick && window_open;
  assign detect_now = do_sample && hit && (run_count + 4'h1 >= need);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= rps_pkg::RPS_IDLE;
      reference <= 3'h0;
    end else begin
      case (state)
        rps_pkg::RPS_IDLE: begin
          if (start_req) begin
            state     <= rps_pkg::RPS_RUN;
            reference <= seen;
          end
        end
        rps_pkg::RPS_RUN: begin
          if (stop_req && !detect_now) begin
            state <= rps_pkg::RPS_STOPPING;
          end else if (stop_req && detect_now) begin
            state <= rps_pkg::RPS_IDLE;
          end
        end
        rps_pkg::RPS_STOPPING: begin
          if (detect_now) begin
            state <= rps_pkg::RPS_IDLE;
          end
        end
        default: state <= rps_pkg::RPS_IDLE;
      endcase
    end
  end

  // limitation: a reserved mode code freezes counting, never detects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_count <= 4'h0;
    end else if (!sampling || detect_now) begin
      run_count <= 4'h0;
    end else if (sample_mode_select == rps_pkg::RPS_SAMPLE_PWM_ON && recount_per_pwm
                 && pwm_prev && !pwm_on) begin
      run_count <= 4'h0;
    end else if (do_sample) begin
      run_count <= hit ? run_count + 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      position_detect <= 1'b0;
    end else begin
      position_detect <= detect_now;
    end
  end

  // -------------------------------------------------------------------------
  // interrupt: set wins over clear
  // -------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 1'b0;
    end else if (detect_now) begin
      irq_status <= 1'b1;
    end else if (irq_clear_pulse) begin
      irq_status <= 1'b0;
    end
  end

  assign irq = irq_status && irq_enable;

  // -------------------------------------------------------------------------
  // axi4-lite read channel
  // -------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RPS_AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RPS_AXI_RESP_OKAY;
      case (s_axi_araddr)
        `RPS_ADDR_CONTROL:    s_axi_rdata <= {24'h00_0000, control_reg};
        `RPS_ADDR_CONFIG:     s_axi_rdata <= {24'h00_0000, config_reg};
        `RPS_ADDR_PATTERN:    s_axi_rdata <= {29'h0000_0000, motor_output_pattern};
        `RPS_ADDR_STATUS:     s_axi_rdata <= {28'h000_0000, sampling, reference};
        `RPS_ADDR_IRQ_STATUS: s_axi_rdata <= {31'h0000_0000, irq_status};
        `RPS_ADDR_IRQ_ENABLE: s_axi_rdata <= {31'h0000_0000, irq_enable};
        `RPS_ADDR_IRQ_CLEAR:  s_axi_rdata <= 32'h0000_0000;
        `RPS_ADDR_PIN_DIR:    s_axi_rdata <= {29'h0000_0000, pin_is_output};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RPS_AXI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  detect_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    detect_now |=> position_detect) else $error("detection pulse missing");
  detect_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    detect_now |-> tick && window_open && sampling) else $error("detect off tick");
  irq_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    detect_now |=> irq_status) else $error("status not set");
  stop_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == rps_pkg::RPS_STOPPING && detect_now |=> state == rps_pkg::RPS_IDLE)
    else $error("stop not taken");
  soft_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == rps_pkg::RPS_IDLE && soft_start_pulse |=> sampling) else $error("start ignored");
  recount_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sampling && !detect_now && sample_mode_select == rps_pkg::RPS_SAMPLE_PWM_ON && recount_per_pwm
    && $fell(pwm_on) |=> run_count == 4'h0) else $error("recount missing");
  single_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    single_pin_select && !detect_mode_select && seen[0] == motor_output_pattern[0] |-> hit)
    else $error("v w not ignored");
  need_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    match_count_target <= 4'h1 && do_sample && hit |-> detect_now) else $error("count zero wrong");
  masked_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_is_output[0] |-> !seen[0]) else $error("output pin seen");

endmodule : rps_sampler

`default_nettype wire

/* bench/rps_position_model.sv */
/*
  Rotor sensor and PWM stage model facing the sampler pins.
  Assumes the bench sets the wanted pin pattern and whether PWM runs.
*/
`timescale 1ns/1ps
`default_nettype none

module rps_position_model (
  input  wire logic       aclk,
  input  wire logic [2:0] want_pattern,
  input  wire logic       pwm_run,
  output logic            phase_u,
  output logic            phase_v,
  output logic            phase_w,
  output logic            pwm_on,
  output logic            low_side_on
);
  logic [4:0] pwm_cnt = 5'h00;

  // ---------------------------------------------------------------------------
  // push-pull sensors, one cycle behind the request
  // ---------------------------------------------------------------------------
  always @(posedge aclk) begin
    {phase_w, phase_v, phase_u} <= want_pattern;
    pwm_cnt                     <= pwm_cnt + 5'h01;
  end

  // on 24 of 32 cycles: too short for 15 ticks at /4, so recount can starve
  assign pwm_on      = pwm_run && (pwm_cnt < 5'h18);
  assign low_side_on = pwm_run && !pwm_on;
endmodule : rps_position_model

`default_nettype wire

/* bench/tb_top.sv */
/*
  Self-checking bench for the rotor position sampler over AXI4-Lite.
  Assumes the core files and the position model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rps_defs.svh"

module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, pwm_run, t_start, t_stop;
  logic        awready, wready, bvalid, arready, rvalid, det, irq, pu, pv, pw, pon, lon;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [2:0]  pat;
  logic [1:0]  r, bresp, rresp;
  int          fails, n_compared, k, c, p;

  rps_sampler i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .phase_u_position_in(pu), .phase_v_position_in(pv), .phase_w_position_in(pw),
    .pwm_on_in(pon), .low_side_on_in(lon), .timer_start_trigger(t_start),
    .timer_stop_trigger(t_stop), .position_detect(det), .irq(irq));

  rps_position_model i_model (
    .aclk(aclk), .want_pattern(pat), .pwm_run(pwm_run), .phase_u(pu), .phase_v(pv),
    .phase_w(pw), .pwm_on(pon), .low_side_on(lon));

  // ---------------------------------------------------------------------------
  // report and bus tasks
  // ---------------------------------------------------------------------------
  task automatic test_done;
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hang;
    chk("wait_bound", 32'h0, 32'h1);
    test_done();
  endtask : hang

  // whole-byte writes only: the control register must never be read-modified
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int   n;
    logic aw, w;
    n  = 0;
    aw = 1'b1;
    w  = 1'b1;
    awaddr  <= a;
    wdata   <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (aw || w) begin
      @(negedge aclk);
      n++;
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      @(posedge aclk);
      awvalid <= aw;
      wvalid  <= w;
      if (n > 50) hang();
    end
    do begin
      @(negedge aclk);
      n++;
    end while (!bvalid && n < 100);
    r = bresp;
    @(posedge aclk);
    if (n >= 100) hang();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      n++;
    end while (!arready && n < 50);
    @(posedge aclk);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    if (n >= 100) hang();
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg_%h", a), e, d);
  endtask : rdc

  // waits up to hi cycles for a detect pulse; lo is the earliest legal cycle
  task automatic wdet(input int lo, input int hi, input logic want);
    int   n;
    logic seen;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      seen = (det === 1'b1);
    end while (!seen && n < hi);
    @(posedge aclk);
    chk("detect", {31'h0, want}, {31'h0, seen});
    if (want) chk("detect_early", 32'h1, {31'h0, n >= lo});
  endtask : wdet

  // ---------------------------------------------------------------------------
  // clock and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    {aresetn, awvalid, wvalid, arvalid, pwm_run, t_start, t_stop} = 7'h00;
    {awaddr, araddr, wdata, pat} = 51'h0;
    fails = 0;
    n_compared = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(`RPS_ADDR_CONFIG, 32'h0);
    rdc(`RPS_ADDR_CONTROL, 32'h0);
    rd(8'h20);
    chk("rresp", `RPS_AXI_RESP_SLVERR, r);
    wr(`RPS_ADDR_STATUS, 8'hFF);
    chk("bresp", `RPS_AXI_RESP_SLVERR, r);
    wr(`RPS_ADDR_PATTERN, 8'h05);
    wr(`RPS_ADDR_IRQ_ENABLE, 8'h01);
    for (k = 0; k < 4; k++) begin
      c = (k == 3) ? 15 : k;
      p = 4 << k;
      pat <= 3'h0;
      wr(`RPS_ADDR_CONFIG, {k[1:0], 2'h1, c[3:0]});
      wr(`RPS_ADDR_CONTROL, 8'h40);
      wr(`RPS_ADDR_CONTROL, 8'h80);
      rdc(`RPS_ADDR_STATUS, 32'h8);
      pat <= 3'h5;
      wdet((c < 2 ? 0 : c - 1) * p, (c < 2 ? 1 : c) * p + 12, 1'b1);
      chk("irq", 32'h1, {31'h0, irq});
      rdc(`RPS_ADDR_STATUS, 32'h0);
      wr(`RPS_ADDR_IRQ_CLEAR, 8'h01);
      chk("irq", 32'h0, {31'h0, irq});
    end
    // change detection against the pattern caught at start, irq masked first
    pat <= 3'h2;
    wr(`RPS_ADDR_IRQ_ENABLE, 8'h00);
    wr(`RPS_ADDR_CONFIG, 8'h52);
    wr(`RPS_ADDR_CONTROL, 8'h42);
    rdc(`RPS_ADDR_STATUS, 32'hA);
    wdet(0, 60, 1'b0);
    pat <= 3'h6;
    wdet(8, 40, 1'b1);
    // back to the start state so no stray detection races the stop write
    pat <= 3'h2;
    chk("irq", 32'h0, {31'h0, irq});
    rdc(`RPS_ADDR_IRQ_STATUS, 32'h1);
    wr(`RPS_ADDR_IRQ_ENABLE, 8'h01);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`RPS_ADDR_CONTROL, 8'h82);
    pat <= 3'h6;
    wdet(0, 40, 1'b1);
    rdc(`RPS_ADDR_STATUS, 32'h2);
    // single pin, then U masked by its direction bit
    pat <= 3'h0;
    wr(`RPS_ADDR_PATTERN, 8'h01);
    wr(`RPS_ADDR_CONFIG, 8'h11);
    wr(`RPS_ADDR_CONTROL, 8'h48);
    wr(`RPS_ADDR_CONTROL, 8'h88);
    pat <= 3'h7;
    wdet(0, 16, 1'b1);
    pat <= 3'h0;
    wr(`RPS_ADDR_PIN_DIR, 8'h01);
    wr(`RPS_ADDR_PATTERN, 8'h06);
    wr(`RPS_ADDR_CONTROL, 8'h40);
    wr(`RPS_ADDR_CONTROL, 8'h80);
    pat <= 3'h7;
    wdet(0, 16, 1'b1);
    wr(`RPS_ADDR_PIN_DIR, 8'h00);
    // timer triggers: start ignored while disabled, then start and stop obeyed once enabled
    pat <= 3'h0;
    t_start <= 1'b1;
    wr(`RPS_ADDR_PATTERN, 8'h05);
    rdc(`RPS_ADDR_STATUS, 32'h0);
    t_start <= 1'b0;
    wr(`RPS_ADDR_CONTROL, 8'h30);
    t_start <= 1'b1;
    wr(`RPS_ADDR_PATTERN, 8'h05);
    rdc(`RPS_ADDR_STATUS, 32'h8);
    t_stop <= 1'b1;
    wr(`RPS_ADDR_PATTERN, 8'h05);
    rdc(`RPS_ADDR_STATUS, 32'h8);
    pat <= 3'h5;
    wdet(0, 16, 1'b1);
    rdc(`RPS_ADDR_STATUS, 32'h0);
    // PWM-on window: shut, then too short for recount, then accumulating
    pat <= 3'h0;
    wr(`RPS_ADDR_CONFIG, 8'h0F);
    wr(`RPS_ADDR_CONTROL, 8'h44);
    pat <= 3'h5;
    wdet(0, 100, 1'b0);
    pwm_run <= 1'b1;
    wdet(0, 300, 1'b0);
    wr(`RPS_ADDR_CONTROL, 8'h80);
    wdet(0, 200, 1'b1);
    pat <= 3'h0;
    wr(`RPS_ADDR_CONFIG, 8'h21);
    wr(`RPS_ADDR_CONTROL, 8'h40);
    wr(`RPS_ADDR_CONTROL, 8'h80);
    pat <= 3'h5;
    wdet(0, 80, 1'b1);
    // reserved mode code: running, pins matching, yet never sampled
    wr(`RPS_ADDR_CONFIG, 8'h31);
    wr(`RPS_ADDR_CONTROL, 8'h40);
    rdc(`RPS_ADDR_STATUS, 32'hD);
    wdet(0, 60, 1'b0);
    test_done();
  end
endmodule : tb_top

`default_nettype wire
